// ==== edc_dma.sv ====
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module edc_dma
  import edc_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_b,
  // Register port
  input  wire logic [EDC_ADR_W-1:0]     i_reg_addr,
  input  wire logic [EDC_DW-1:0]        i_reg_wdata,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  output logic      [EDC_DW-1:0]        o_reg_rdata,
  // Peripheral requests and indirect offsets, channel n in bits n*16 upward
  input  wire logic [EDC_NREQ-1:0]      i_req_lines,
  input  wire logic [EDC_NCH*EDC_DW-1:0] i_periph_offset,
  // DMA RAM port
  output logic      [EDC_DW-1:0]        o_ram_addr,
  output logic      [EDC_DW-1:0]        o_ram_wdata,
  output logic                          o_ram_wr,
  output logic                          o_ram_rd,
  output logic                          o_ram_byte,
  input  wire logic [EDC_DW-1:0]        i_ram_rdata,
  // Peripheral port
  output logic      [EDC_DW-1:0]        o_per_addr,
  output logic      [EDC_DW-1:0]        o_per_wdata,
  output logic                          o_per_wr,
  output logic                          o_per_rd,
  output logic                          o_per_byte,
  input  wire logic [EDC_DW-1:0]        i_per_rdata,
  // Per-channel interrupt requests
  output logic      [EDC_NCH-1:0]       o_chan_irq
);

  edc_state_t             state_r;
  logic [EDC_CH_W-1:0]    chan_r;
  logic                   dir_r;
  logic                   null_r;
  logic                   byte_r;
  logic [EDC_DW-1:0]      ram_addr_r;
  logic [EDC_DW-1:0]      per_addr_r;
  logic [EDC_DW-1:0]      data_r;
  logic [EDC_DW-1:0]      per_wdata_r;
  logic [EDC_DW-1:0]      rdata_r;

  logic [EDC_DW-1:0]      ctrl_w   [EDC_NCH];
  logic [EDC_DW-1:0]      reqsel_w [EDC_NCH];
  logic [EDC_DW-1:0]      pri_w    [EDC_NCH];
  logic [EDC_DW-1:0]      sec_w    [EDC_NCH];
  logic [EDC_DW-1:0]      padr_w   [EDC_NCH];
  logic [EDC_CNT_W-1:0]   cnt_w    [EDC_NCH];
  logic [EDC_DW-1:0]      poff_w   [EDC_NCH];
  logic [EDC_CNT_W-1:0]   idx_r    [EDC_NCH];
  logic [EDC_NCH-1:0]     pend_r;
  logic [EDC_NCH-1:0]     pp_r;
  logic [EDC_NCH-1:0]     irq_r;
  logic [EDC_NCH-1:0]     trig_w;
  logic [EDC_NCH-1:0]     fin_w;
  logic [EDC_NCH-1:0]     stop_w;

  logic                   grant_any;
  logic [EDC_CH_W-1:0]    gnt;
  logic [EDC_CH_W-1:0]    reg_ch;
  logic [EDC_RIX_W-1:0]   reg_idx;

  assign reg_ch  = i_reg_addr[EDC_ADR_W-1:EDC_RIX_W];
  assign reg_idx = i_reg_addr[EDC_RIX_W-1:0];

  genvar g;
  generate
    for (g = 0; g < EDC_NCH; g++) begin : g_ch
      logic on_w;
      logic force_w;
      logic req_hit_w;
      logic busy_w;
      logic last_w;
      logic half_w;
      logic pp_en_w;
      logic os_w;
      logic irq_ev_w;
      logic [EDC_SEL_W-1:0] sel_w;

      edc_chan_regs u_regs (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_wr        (i_reg_wr && (reg_ch == EDC_CH_W'(g))),
        .i_reg_idx   (reg_idx),
        .i_wdata     (i_reg_wdata),
        .i_hw_off    (stop_w[g]),
        .i_force_clr (fin_w[g] && force_w),
        .o_ctrl      (ctrl_w[g]),
        .o_reqsel    (reqsel_w[g]),
        .o_pri       (pri_w[g]),
        .o_sec       (sec_w[g]),
        .o_padr      (padr_w[g]),
        .o_cnt       (cnt_w[g])
      );

      assign poff_w[g]  = i_periph_offset[g*EDC_DW +: EDC_DW];
      assign on_w       = ctrl_w[g][EDC_CTRL_ON_BIT];
      assign force_w    = reqsel_w[g][EDC_REQ_FORCE_BIT];
      assign sel_w      = reqsel_w[g][EDC_SEL_W-1:0];
      assign req_hit_w  = i_req_lines[sel_w] && EDC_USABLE_REQ[sel_w];
      assign busy_w     = (state_r != EDC_ST_IDLE) && (chan_r == EDC_CH_W'(g));
      // A forced transfer is queued once; the force bit stays high until it ends
      assign trig_w[g]  = on_w && (force_w ? (!pend_r[g] && !busy_w) : req_hit_w);
      assign fin_w[g]   = (state_r == EDC_ST_WRITE) && (chan_r == EDC_CH_W'(g));
      assign last_w     = (idx_r[g] == cnt_w[g]);
      assign half_w     = (idx_r[g] == (cnt_w[g] >> 1));
      assign pp_en_w    = ctrl_w[g][EDC_MODE_PP_BIT];
      assign os_w       = ctrl_w[g][EDC_MODE_OS_BIT];
      assign stop_w[g]  = fin_w[g] && last_w && os_w && (!pp_en_w || pp_r[g]);
      assign irq_ev_w   = fin_w[g] && (ctrl_w[g][EDC_CTRL_HALF_BIT] ? half_w : last_w);

      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          pend_r[g] <= 1'b0;
          pp_r[g]   <= 1'b0;
          irq_r[g]  <= 1'b0;
          idx_r[g]  <= EDC_ZERO_CNT;
        end else begin
          irq_r[g] <= irq_ev_w;
          if (trig_w[g]) begin
            pend_r[g] <= 1'b1;
          end else if (!on_w || (state_r == EDC_ST_IDLE && grant_any &&
                                 gnt == EDC_CH_W'(g))) begin
            pend_r[g] <= 1'b0;
          end
          if (!on_w) begin
            idx_r[g] <= EDC_ZERO_CNT;
            pp_r[g]  <= 1'b0;
          end else if (fin_w[g]) begin
            if (last_w) begin
              idx_r[g] <= EDC_ZERO_CNT;
              if (pp_en_w) begin
                pp_r[g] <= !pp_r[g];
              end
            end else begin
              idx_r[g] <= idx_r[g] + 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // Fixed priority: channel 0 wins; a busy low channel can starve higher ones
  always_comb begin
    grant_any = 1'b0;
    gnt       = '0;
    for (int i = EDC_NCH - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        grant_any = 1'b1;
        gnt       = EDC_CH_W'(i);
      end
    end
  end

  // RAM address of the granted channel's next transfer
  logic [EDC_DW-1:0] g_ctrl;
  logic [EDC_DW-1:0] g_base;
  logic [EDC_DW-1:0] g_step_ofs;
  logic [EDC_DW-1:0] g_ram_addr;
  logic [1:0]        g_amode;
  logic              g_byte;
  logic              g_dir;

  assign g_ctrl     = ctrl_w[gnt];
  assign g_byte     = g_ctrl[EDC_CTRL_BYTE_BIT];
  assign g_dir      = g_ctrl[EDC_CTRL_DIR_BIT];
  assign g_amode    = g_ctrl[EDC_CTRL_AM_LSB +: 2];
  assign g_base     = pp_r[gnt] ? sec_w[gnt] : pri_w[gnt];
  assign g_step_ofs = g_byte ? EDC_DW'(idx_r[gnt]) * EDC_STEP_BYTE
                             : EDC_DW'(idx_r[gnt]) * EDC_STEP_WORD;
  // Reserved addressing mode behaves as no increment
  assign g_ram_addr = (g_amode == EDC_AM_POSTINC) ? g_base + g_step_ofs :
                      (g_amode == EDC_AM_PERIND)  ? g_base + poff_w[gnt] :
                                                    g_base;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= EDC_ST_IDLE;
    end else begin
      case (state_r)
        EDC_ST_IDLE:  state_r <= grant_any ? EDC_ST_READ : EDC_ST_IDLE;
        EDC_ST_READ:  state_r <= EDC_ST_CAPT;
        EDC_ST_CAPT:  state_r <= EDC_ST_WRITE;
        EDC_ST_WRITE: state_r <= EDC_ST_IDLE;
        default:      state_r <= EDC_ST_IDLE;
      endcase
    end
  end

  // Transfer context, latched at grant so register writes mid-transfer do no harm
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chan_r     <= '0;
      dir_r      <= 1'b0;
      null_r     <= 1'b0;
      byte_r     <= 1'b0;
      ram_addr_r <= EDC_ZERO16;
      per_addr_r <= EDC_ZERO16;
    end else if (state_r == EDC_ST_IDLE && grant_any) begin
      chan_r     <= gnt;
      dir_r      <= g_dir;
      null_r     <= g_ctrl[EDC_CTRL_NULL_BIT] && !g_dir;
      byte_r     <= g_byte;
      ram_addr_r <= g_ram_addr;
      per_addr_r <= padr_w[gnt];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_r      <= EDC_ZERO16;
      per_wdata_r <= EDC_ZERO16;
    end else if (state_r == EDC_ST_CAPT) begin
      data_r      <= dir_r ? i_ram_rdata : i_per_rdata;
      per_wdata_r <= dir_r ? i_ram_rdata : EDC_ZERO16;
    end
  end

  // Dedicated transfer ports
  assign o_ram_addr  = ram_addr_r;
  assign o_ram_wdata = data_r;
  assign o_ram_byte  = byte_r;
  assign o_per_addr  = per_addr_r;
  assign o_per_wdata = per_wdata_r;
  assign o_per_byte  = byte_r;
  assign o_ram_rd    = (state_r == EDC_ST_READ) && dir_r;
  assign o_per_rd    = (state_r == EDC_ST_READ) && !dir_r;
  assign o_ram_wr    = (state_r == EDC_ST_WRITE) && !dir_r;
  assign o_per_wr    = (state_r == EDC_ST_WRITE) && (dir_r || null_r);
  assign o_chan_irq  = irq_r;

  // Register read path
  logic [EDC_DW-1:0] stat_w;
  logic [EDC_DW-1:0] rd_mux_w;

  assign stat_w = EDC_DW'({pend_r[reg_ch], pp_r[reg_ch]});
  assign rd_mux_w = (reg_idx == EDC_REG_CTRL) ? ctrl_w[reg_ch] :
                    (reg_idx == EDC_REG_REQ)  ? reqsel_w[reg_ch] :
                    (reg_idx == EDC_REG_PRI)  ? pri_w[reg_ch] :
                    (reg_idx == EDC_REG_SEC)  ? sec_w[reg_ch] :
                    (reg_idx == EDC_REG_PAD)  ? padr_w[reg_ch] :
                    (reg_idx == EDC_REG_CNT)  ? EDC_DW'(cnt_w[reg_ch]) :
                    (reg_idx == EDC_REG_STAT) ? stat_w :
                                                EDC_ZERO16;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= EDC_ZERO16;
    end else begin
      rdata_r <= i_reg_rd ? rd_mux_w : EDC_ZERO16;
    end
  end

  assign o_reg_rdata = rdata_r;

endmodule

// ==== edc_pkg.sv ====
package edc_pkg;

  // Geometry
  localparam int EDC_NCH   = 8;
  localparam int EDC_CH_W  = 3;
  localparam int EDC_DW    = 16;
  localparam int EDC_CNT_W = 10;
  localparam int EDC_SEL_W = 7;
  localparam int EDC_NREQ  = 128;
  localparam int EDC_ADR_W = 6;
  localparam int EDC_RIX_W = 3;

  // Register index inside a channel's group of eight words
  localparam logic [2:0] EDC_REG_CTRL = 3'h0;
  localparam logic [2:0] EDC_REG_REQ  = 3'h1;
  localparam logic [2:0] EDC_REG_PRI  = 3'h2;
  localparam logic [2:0] EDC_REG_SEC  = 3'h3;
  localparam logic [2:0] EDC_REG_PAD  = 3'h4;
  localparam logic [2:0] EDC_REG_CNT  = 3'h5;
  localparam logic [2:0] EDC_REG_STAT = 3'h6;

  // Control field positions
  localparam int EDC_CTRL_ON_BIT    = 15;
  localparam int EDC_CTRL_BYTE_BIT  = 14;
  localparam int EDC_CTRL_DIR_BIT   = 13;
  localparam int EDC_CTRL_HALF_BIT  = 12;
  localparam int EDC_CTRL_NULL_BIT  = 11;
  localparam int EDC_CTRL_AM_LSB    = 4;
  localparam int EDC_MODE_PP_BIT    = 1;
  localparam int EDC_MODE_OS_BIT    = 0;
  localparam int EDC_REQ_FORCE_BIT  = 15;
  localparam int EDC_STAT_PP_BIT    = 0;
  localparam int EDC_STAT_PEND_BIT  = 1;

  // Implemented bits
  localparam logic [15:0] EDC_CTRL_MASK = 16'hF833;
  localparam logic [15:0] EDC_REQ_MASK  = 16'h807F;

  // Addressing modes
  localparam logic [1:0] EDC_AM_POSTINC = 2'h0;
  localparam logic [1:0] EDC_AM_NOINC   = 2'h1;
  localparam logic [1:0] EDC_AM_PERIND  = 2'h2;

  // Request lines that are wired to a peripheral able to trigger a channel
  localparam logic [127:0] EDC_USABLE_REQ = 128'h0000_0000_0000_00C0_0080_0006_C020_3DE7;

  localparam logic [15:0] EDC_STEP_BYTE = 16'h0001;
  localparam logic [15:0] EDC_STEP_WORD = 16'h0002;
  localparam logic [15:0] EDC_ZERO16    = 16'h0000;
  localparam logic [9:0]  EDC_ZERO_CNT  = 10'h000;

  typedef enum logic [1:0] {
    EDC_ST_IDLE,
    EDC_ST_READ,
    EDC_ST_CAPT,
    EDC_ST_WRITE
  } edc_state_t;

endpackage

// ==== edc_chan_regs.sv ====
`timescale 1ns/1ps
module edc_chan_regs
  import edc_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_b,
  // Register write from the decoder
  input  wire logic                 i_wr,
  input  wire logic [EDC_RIX_W-1:0] i_reg_idx,
  input  wire logic [EDC_DW-1:0]    i_wdata,
  // Engine events
  input  wire logic                 i_hw_off,
  input  wire logic                 i_force_clr,
  // Register contents
  output logic      [EDC_DW-1:0]    o_ctrl,
  output logic      [EDC_DW-1:0]    o_reqsel,
  output logic      [EDC_DW-1:0]    o_pri,
  output logic      [EDC_DW-1:0]    o_sec,
  output logic      [EDC_DW-1:0]    o_padr,
  output logic      [EDC_CNT_W-1:0] o_cnt
);

  logic ctrl_we;
  logic req_we;
  logic force_nxt;

  assign ctrl_we = i_wr && (i_reg_idx == EDC_REG_CTRL);
  assign req_we  = i_wr && (i_reg_idx == EDC_REG_REQ);
  // Software can only set the force bit; a write in the clearing cycle wins
  assign force_nxt = (req_we && i_wdata[EDC_REQ_FORCE_BIT]) ||
                     (o_reqsel[EDC_REQ_FORCE_BIT] && !i_force_clr);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ctrl   <= EDC_ZERO16;
      o_reqsel <= EDC_ZERO16;
      o_pri    <= EDC_ZERO16;
      o_sec    <= EDC_ZERO16;
      o_padr   <= EDC_ZERO16;
      o_cnt    <= EDC_ZERO_CNT;
    end else begin
      if (ctrl_we) begin
        o_ctrl <= i_wdata & EDC_CTRL_MASK;
      end else if (i_hw_off) begin
        o_ctrl[EDC_CTRL_ON_BIT] <= 1'b0;
      end
      if (req_we) begin
        o_reqsel[EDC_SEL_W-1:0] <= i_wdata[EDC_SEL_W-1:0];
      end
      o_reqsel[EDC_REQ_FORCE_BIT] <= force_nxt;
      if (i_wr && (i_reg_idx == EDC_REG_PRI)) begin
        o_pri <= i_wdata;
      end
      if (i_wr && (i_reg_idx == EDC_REG_SEC)) begin
        o_sec <= i_wdata;
      end
      if (i_wr && (i_reg_idx == EDC_REG_PAD)) begin
        o_padr <= i_wdata;
      end
      if (i_wr && (i_reg_idx == EDC_REG_CNT)) begin
        o_cnt <= i_wdata[EDC_CNT_W-1:0];
      end
    end
  end

endmodule

// ==== edc_dma_checker.sv ====
`timescale 1ns/1ps
module edc_dma_checker
  import edc_pkg::*;
(
  // Clock and reset
  input wire logic               i_sys_clk,
  input wire logic               i_rst_b,
  // Register read
  input wire logic               i_reg_rd,
  input wire logic [EDC_DW-1:0]  o_reg_rdata,
  // RAM side
  input wire logic [EDC_DW-1:0]  o_ram_addr,
  input wire logic [EDC_DW-1:0]  o_ram_wdata,
  input wire logic               o_ram_wr,
  input wire logic               o_ram_rd,
  input wire logic               o_ram_byte,
  // Peripheral side
  input wire logic [EDC_DW-1:0]  o_per_addr,
  input wire logic [EDC_DW-1:0]  o_per_wdata,
  input wire logic               o_per_wr,
  input wire logic               o_per_rd,
  input wire logic               o_per_byte,
  input wire logic [EDC_DW-1:0]  i_per_rdata,
  input wire logic [EDC_NCH-1:0] o_chan_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic any_rd;
  logic both_wr;
  assign any_rd  = o_ram_rd | o_per_rd;
  assign both_wr = o_ram_wr & o_per_wr;

  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  one_source_a: assert property (!(o_ram_rd && o_per_rd))
    else $error("both read strobes at once");
  ram_to_per_a: assert property (o_ram_rd |-> ##2 (o_per_wr && !o_ram_wr))
    else $error("RAM read not followed by peripheral write");
  per_to_ram_a: assert property (o_per_rd |-> ##2 o_ram_wr)
    else $error("peripheral read not followed by RAM write");
  data_pass_a: assert property (o_per_rd ##2 o_ram_wr |-> o_ram_wdata == $past(i_per_rdata))
    else $error("RAM write data differs from peripheral data");
  null_zero_a: assert property (both_wr |-> o_per_wdata == 16'h0000)
    else $error("null write carries data");
  null_dir_a: assert property (both_wr |-> $past(o_per_rd, 2))
    else $error("null write outside peripheral to RAM transfer");
  byte_same_a: assert property (o_ram_byte == o_per_byte)
    else $error("byte flags disagree");
  addr_hold_a: assert property (any_rd |=> ($stable(o_ram_addr) && $stable(o_per_addr)) [*2])
    else $error("address moved inside a transfer");
  read_space_a: assert property (any_rd |=> !any_rd [*3])
    else $error("transfers overlap");
  irq_cause_a: assert property (o_chan_irq != 8'h00 |-> $past(o_ram_wr || o_per_wr))
    else $error("interrupt without a preceding write");
  irq_single_a: assert property ($onehot0(o_chan_irq))
    else $error("more than one channel interrupt");

  cover property (o_chan_irq != 8'h00);
  cover property (both_wr);
  cover property (o_ram_rd ##2 o_per_wr);
endmodule

bind edc_dma edc_dma_checker i_chk (
  .i_sys_clk, .i_rst_b, .i_reg_rd, .o_reg_rdata, .o_ram_addr, .o_ram_wdata, .o_ram_wr,
  .o_ram_rd, .o_ram_byte, .o_per_addr, .o_per_wdata, .o_per_wr, .o_per_rd, .o_per_byte,
  .i_per_rdata, .o_chan_irq
);

// ==== edc_periph_model.sv ====
`timescale 1ns/1ps
module edc_periph_model
  import edc_pkg::*;
(
  // Clock
  input  wire logic              i_sys_clk,
  // Requests from the engine
  input  wire logic [EDC_DW-1:0] i_ram_addr,
  input  wire logic              i_ram_rd,
  input  wire logic [EDC_DW-1:0] i_per_addr,
  input  wire logic              i_per_rd,
  // Read data back
  output logic      [EDC_DW-1:0] o_ram_rdata = 16'h0000,
  output logic      [EDC_DW-1:0] o_per_rdata = 16'h0000
);
  // Data are valid only in the cycle after a strobe; otherwise they toggle,
  // so a capture one cycle early or late is caught by the data compare
  always @(posedge i_sys_clk) begin
    o_ram_rdata <= i_ram_rd ? (i_ram_addr ^ 16'h5A5A) : ~o_ram_rdata;
    o_per_rdata <= i_per_rd ? (i_per_addr ^ 16'hA5A5) : ~o_per_rdata;
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top
  import edc_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [5:0]   addr = 6'h00;
  logic [15:0]  wdata = 16'h0000;
  logic         wr_s = 1'b0;
  logic         rd_s = 1'b0;
  logic [127:0] req = 128'h0;
  logic [127:0] poff = 128'h0000_0000_0000_0000_0000_0010_0000_0000;
  logic [15:0]  rdata, ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
  logic         ram_wr, ram_rd, per_wr, per_rd, ram_byte, per_byte;
  logic [7:0]   irq_o;
  int           errors = 0;
  int           checked = 0;

  edc_dma i_dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_req_lines(req),
    .i_periph_offset(poff), .o_ram_addr(ram_addr), .o_ram_wdata(ram_wdata),
    .o_ram_wr(ram_wr), .o_ram_rd(ram_rd), .o_ram_byte(ram_byte), .i_ram_rdata(ram_rdata),
    .o_per_addr(per_addr), .o_per_wdata(per_wdata), .o_per_wr(per_wr), .o_per_rd(per_rd),
    .o_per_byte(per_byte), .i_per_rdata(per_rdata), .o_chan_irq(irq_o)
  );
  edc_periph_model i_peri (
    .i_sys_clk(clk), .i_ram_addr(ram_addr), .i_ram_rd(ram_rd), .i_per_addr(per_addr),
    .i_per_rd(per_rd), .o_ram_rdata(ram_rdata), .o_per_rdata(per_rdata)
  );

  always #10 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  task automatic regchk(input logic [2:0] idx, input logic [15:0] w, input logic [15:0] e);
    wr({3'h3, idx}, w);
    rdc({3'h3, idx}, e);
  endtask

  task automatic pulse(input int l);
    @(posedge clk);
    req[l] <= 1'b1;
    @(posedge clk);
    req[l] <= 1'b0;
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 `CHK(ram_rd | per_rd | ram_wr | per_wr, 1'b0)
    end
  endtask

  // Waits for the write strobe of one transfer, then checks it and the interrupt after it
  task automatic xfer(input logic [15:0] ra, input logic [15:0] pa, input logic dir,
                      input logic nul, input logic [7:0] irq);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while ((ram_wr | per_wr) !== 1'b1 && k < 20);
    if (k == 20) begin
      errors++;
      end_of_test();
    end
    `CHK(ram_addr, ra)
    `CHK(per_addr, pa)
    `CHK({ram_wr, per_wr}, {!dir, dir | nul})
    if (dir) `CHK(per_wdata, ra ^ 16'h5A5A)
    else `CHK(ram_wdata, pa ^ 16'hA5A5)
    if (nul) `CHK(per_wdata, 16'h0000)
    @(posedge clk);
    #1 `CHK(irq_o, irq)
  endtask

  task automatic t_regs();
    rdc(6'h18, 16'h0000);
    regchk(3'h0, 16'h7FFF, 16'h7833);
    regchk(3'h1, 16'h7FFF, 16'h007F);
    regchk(3'h2, 16'hBEEF, 16'hBEEF);
    regchk(3'h3, 16'h1234, 16'h1234);
    regchk(3'h4, 16'hCAFE, 16'hCAFE);
    regchk(3'h5, 16'hFFFF, 16'h03FF);
    regchk(3'h6, 16'hFFFF, 16'h0000);
    regchk(3'h7, 16'hFFFF, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_force();
    wr(6'h02, 16'h0100);
    wr(6'h04, 16'h0040);
    // Address and count are only written while the channel is off
    wr(6'h05, 16'h0001);
    wr(6'h00, 16'h8000);
    wr(6'h01, 16'h8000);
    xfer(16'h0100, 16'h0040, 1'b0, 1'b0, 8'h00);
    `CHK({ram_byte, per_byte}, 2'b00)
    rdc(6'h01, 16'h0000);
    wr(6'h01, 16'h8000);
    xfer(16'h0102, 16'h0040, 1'b0, 1'b0, 8'h01);
    wr(6'h01, 16'h8000);
    xfer(16'h0100, 16'h0040, 1'b0, 1'b0, 8'h00);
    wr(6'h00, 16'h0000);
    $display("test force done");
  endtask

  task automatic t_null();
    wr(6'h12, 16'h0400);
    wr(6'h14, 16'h0050);
    wr(6'h15, 16'h0001);
    wr(6'h11, 16'h0003);
    wr(6'h10, 16'h8811);
    pulse(3);
    quiet(12);
    wr(6'h11, 16'h000B);
    for (int i = 0; i < 2; i++) begin
      pulse(11);
      xfer(16'h0400, 16'h0050, 1'b0, 1'b1, (i == 1) ? 8'h04 : 8'h00);
    end
    wr(6'h10, 16'h8021);
    pulse(11);
    xfer(16'h0410, 16'h0050, 1'b0, 1'b0, 8'h00);
    wr(6'h10, 16'h0000);
    $display("test null done");
  endtask

  task automatic t_pingpong();
    wr(6'h0A, 16'h0200);
    wr(6'h0B, 16'h0300);
    wr(6'h0C, 16'h0060);
    wr(6'h0D, 16'h0003);
    wr(6'h09, 16'h000A);
    wr(6'h08, 16'hF003);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) rdc(6'h0E, 16'h0001);
      pulse(10);
      xfer(((i < 4) ? 16'h0200 : 16'h0300) + 16'(i % 4), 16'h0060, 1'b1, 1'b0,
           (i % 4 == 1) ? 8'h02 : 8'h00);
      `CHK({ram_byte, per_byte}, 2'b11)
    end
    rdc(6'h08, 16'h7003);
    pulse(10);
    quiet(12);
    $display("test pingpong done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_force();
    t_null();
    t_pingpong();
    end_of_test();
  end
endmodule
